/* hdl/hpi_pkg.sv */
// constants, field layouts and carriers for the homing parameter interlock
// assumes a single 200 MHz clock and a 32-bit ahb-lite register bus
package hpi_pkg;

	// axis count and bus geometry
	localparam int          NUM_AXES  = 4;
	localparam int          ADDR_BITS = 8;

	// register byte offsets
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_POST_DOG = 8'h04;
	localparam logic [7:0]  ADDR_SHIFT    = 8'h08;
	localparam logic [7:0]  ADDR_DWELL    = 8'h0C;
	localparam logic [7:0]  ADDR_TORQUE   = 8'h10;
	localparam logic [7:0]  ADDR_PROG     = 8'h14;
	localparam logic [7:0]  ADDR_STATUS   = 8'h18;
	localparam logic [7:0]  ADDR_TRAVEL   = 8'h1C;
	localparam logic [7:0]  ADDR_FLAG_SET = 8'h20;

	// control register layout, bits 13:0 hold the struct, bit 16 starts homing
	typedef struct packed {
		logic [3:0] method;
		logic       real_mode;
		logic       test_mode;
		logic       abs_system;
		logic       zphase_pass_option;
		logic       incomplete_stop;
		logic       shift_creep;
		logic       retry_en;
		logic       home_dir;
		logic [1:0] axis;
	} hpi_ctrl_s;
	localparam int          CTRL_W      = 14;
	localparam int          CTRL_START  = 16;
	localparam logic [13:0] CTRL_RESET  = 14'h0220;

	// program start request layout
	localparam int          PROG_HOME_ONLY = 4;
	localparam int          PROG_VIRTUAL   = 5;
	localparam int          PROG_JOG       = 6;

	// status register layout
	localparam int          ST_BUSY     = 4;
	localparam int          ST_DONE     = 5;
	localparam int          ST_ACCEPT   = 6;
	localparam int          ST_REFUSE   = 7;
	localparam int          ST_ZPH_ERR  = 8;
	localparam int          ST_LIM_ERR  = 9;
	localparam int          ST_TRV_BAD  = 10;
	localparam int          ST_CODE_LSB = 16;

	// reset values
	localparam logic [3:0]  FLAGS_RESET   = 4'hF;
	localparam logic [15:0] DWELL_RESET   = 16'h0000;
	localparam logic [15:0] TORQUE_RESET  = 16'h0000;
	localparam logic [7:0]  ERR_NOT_HOMED = 8'h79;

	// homing method encodings
	localparam logic [3:0]  M_DOG1     = 4'h0;
	localparam logic [3:0]  M_DOG2     = 4'h1;
	localparam logic [3:0]  M_COUNT1   = 4'h2;
	localparam logic [3:0]  M_COUNT2   = 4'h3;
	localparam logic [3:0]  M_COUNT3   = 4'h4;
	localparam logic [3:0]  M_DSET1    = 4'h5;
	localparam logic [3:0]  M_DSET2    = 4'h6;
	localparam logic [3:0]  M_CRADLE   = 4'h7;
	localparam logic [3:0]  M_STOP1    = 4'h8;
	localparam logic [3:0]  M_STOP2    = 4'h9;
	localparam logic [3:0]  M_LIMSW    = 4'hA;
	localparam logic [3:0]  M_SCALE    = 4'hB;
	localparam logic [3:0]  M_DOGLESSA = 4'hC;
	localparam logic [3:0]  M_DOGLESSB = 4'hD;
	localparam logic [3:0]  M_DOGLESSC = 4'hE;
	localparam logic [3:0]  M_DRIVER   = 4'hF;

	// dwell unit is one millisecond
	localparam int          CLK_PERIOD_PS = 5000;
	localparam int          DWELL_UNIT_PS = 1000000000;
	localparam int          MS_CYCLES     = DWELL_UNIT_PS / CLK_PERIOD_PS;

	// pin input indices into the synchroniser
	localparam int          PIN_DOG  = 0;
	localparam int          PIN_ZERO = 1;
	localparam int          PIN_STEP = 2;
	localparam int          PIN_LIM  = 3;
	localparam int          PIN_REF  = 4;
	localparam int          PIN_AMP  = 5;
	localparam int          PIN_W    = 5 + NUM_AXES;

	// motion command bundle to the amplifier
	typedef struct packed {
		logic run;
		logic dir;
		logic creep;
		logic torque_lim_en;
	} hpi_motion_s;

endpackage

/* hdl/hpi_pin_sync.sv */
// three-stage synchroniser with agreement filter for pin inputs
// assumes inputs are asynchronous to hclk; output is a clean level
`timescale 1ns/10ps
module hpi_pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// raw pins and filtered levels
	input  wire logic [W-1:0] pin_raw,
	output logic      [W-1:0] pin_level
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// stage1 feeds stage2 only; a change counts when stage2 and stage3 agree
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage1    <= '0;
			stage2    <= '0;
			stage3    <= '0;
			pin_level <= '0;
		end else begin
			stage1    <= pin_raw;
			stage2    <= stage1;
			stage3    <= stage2;
			pin_level <= (stage2 & stage3) | (pin_level & (stage2 | stage3));
		end
	end

endmodule

/* hdl/hpi_top.sv */
// homing sequencer, homing parameters and servo-program start interlock
// assumes one ahb-lite master, 200 MHz hclk, sensor pins asynchronous
//
// How it works
// - count method: travel distance after dog, then zero
// - zphase pass option 1 lifts that restriction
// - retry pauses for dwell at each reversal
// - retry only for dog, count, cradle, dogless A
// - shift moves from zero by signed amount
// - nonzero shift runs at homing or creep speed
// - shift ignored for data set, stopper, driver
// - post-dog travel overflow marks monitor invalid
// - creep torque limit only for stopper methods
// - setting 1 refuses programs on unhomed axes
// - refused start raises minor error 121
// - jog and manual pulser always allowed
// - non-absolute system sets request flag at power-up
// - test mode interlocks the same way
// - interlock real mode only, virtual axes run
// - setting 0 starts programs regardless of flag
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module hpi_top #(
	parameter int MS_CYCLES = hpi_pkg::MS_CYCLES
) (
	// clock and reset
	input  wire logic                          hclk,
	input  wire logic                          hresetn,
	// ahb-lite slave
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic                               hreadyout,
	output logic                               hresp,
	output logic [31:0]                        hrdata,
	// sensor and amplifier pins
	input  wire logic                          dog_in,
	input  wire logic                          zero_pulse_in,
	input  wire logic                          enc_step_in,
	input  wire logic                          limit_in,
	input  wire logic                          ref_passed_in,
	input  wire logic [hpi_pkg::NUM_AXES-1:0]  amp_power_up_in,
	// motion command
	output hpi_pkg::hpi_motion_s               motion,
	output logic [15:0]                        torque_limit,
	// program start answer and axis flags
	output logic [hpi_pkg::NUM_AXES-1:0]       homing_request_flag,
	output logic                               prog_go,
	output logic                               prog_err
);
	import hpi_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_FAST, S_DWELL, S_COUNT, S_SEEK, S_SHIFT, S_PRESS, S_DONE} hpi_state_e;

	// method decoders used by sequencer and checks
	function automatic logic retry_ok(input logic [3:0] m);
		retry_ok = (m == M_DOG1) || (m == M_DOG2) || (m == M_COUNT1) || (m == M_COUNT2) ||
		           (m == M_COUNT3) || (m == M_CRADLE) || (m == M_DOGLESSA);
	endfunction
	function automatic logic shift_ok(input logic [3:0] m);
		shift_ok = !((m == M_DSET1) || (m == M_DSET2) || (m == M_STOP1) || (m == M_STOP2) || (m == M_DRIVER));
	endfunction
	function automatic logic is_count(input logic [3:0] m);
		is_count = (m == M_COUNT1) || (m == M_COUNT2) || (m == M_COUNT3);
	endfunction
	function automatic logic is_stopper(input logic [3:0] m);
		is_stopper = (m == M_STOP1) || (m == M_STOP2);
	endfunction

	// registers
	hpi_ctrl_s          ctrl;
	logic [31:0]        post_dog;
	logic [31:0]        shift_amt;
	logic [15:0]        dwell_ms;
	logic [15:0]        torque_reg;
	logic [31:0]        travel_mon;
	logic               travel_bad;
	logic               done_flag;
	logic               accept_flag;
	logic               refuse_flag;
	logic               zph_err;
	logic               lim_err;
	logic [7:0]         err_code;
	// bus data phase
	logic               dph_wr;
	logic [7:0]         dph_addr;
	// sequencer
	hpi_state_e         state;
	hpi_state_e         next_state;
	logic [3:0]         meth_lat;
	logic [1:0]         axis_lat;
	logic [31:0]        post_lat;
	logic [31:0]        sh_lat;
	logic               dir_q;
	logic [31:0]        cnt;
	logic [31:0]        ms_cnt;
	logic               step_q;
	logic               zero_q;
	logic [NUM_AXES-1:0] amp_q;
	logic               lim_hold;
	logic [PIN_W-1:0]   pins;

	// pin conditioning
	hpi_pin_sync #(.W(PIN_W)) u_sync (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.pin_raw   ({amp_power_up_in, ref_passed_in, limit_in, enc_step_in, zero_pulse_in, dog_in}),
		.pin_level (pins)
	);

	// bus decode
	wire                addr_ph   = hsel && htrans[1] && hready;
	wire [7:0]          a_addr    = haddr[7:0];
	wire                wr_ctrl   = dph_wr && (dph_addr == ADDR_CTRL);
	wire                wr_prog   = dph_wr && (dph_addr == ADDR_PROG);
	wire                wr_fset   = dph_wr && (dph_addr == ADDR_FLAG_SET);
	wire                start_req = wr_ctrl && hwdata[CTRL_START];
	wire hpi_ctrl_s     ctrl_wd   = hwdata[CTRL_W-1:0];
	// edges of filtered pins
	wire                step_rise = pins[PIN_STEP] && !step_q;
	wire                zero_rise = pins[PIN_ZERO] && !zero_q;
	wire [NUM_AXES-1:0] amp_rise  = pins[PIN_AMP +: NUM_AXES] & ~amp_q;
	// only read with start_req: the start write carries its own pass option
	wire                ref_ok    = pins[PIN_REF] || ctrl_wd.zphase_pass_option;
	// a limit being backed away from after a retry must not trigger again
	wire                lim_hit   = pins[PIN_LIM] && !lim_hold;
	wire [31:0]         sh_mag    = sh_lat[31] ? (32'h0000_0000 - sh_lat) : sh_lat;
	wire                do_shift  = shift_ok(meth_lat) && (sh_lat != 32'h0000_0000);
	wire [32:0]         trv_sum   = {post_lat[31], post_lat} + {sh_lat[31], sh_lat};
	wire                trv_ovf   = trv_sum[32] ^ trv_sum[31];
	wire                ms_tick   = (state == S_DWELL) && (ms_cnt == 32'(MS_CYCLES - 1));

	// start interlock; test mode deliberately plays no part
	wire [NUM_AXES-1:0] prog_axes = hwdata[NUM_AXES-1:0];
	wire                exempt    = hwdata[PROG_HOME_ONLY] || hwdata[PROG_JOG] || hwdata[PROG_VIRTUAL];
	wire                refuse    = ctrl.incomplete_stop && ctrl.real_mode && !exempt &&
	                                |(prog_axes & homing_request_flag);

	// request flag set sources; set beats the done clear
	wire [NUM_AXES-1:0] flag_set  = (wr_fset ? hwdata[NUM_AXES-1:0] : '0) |
	                                (ctrl.abs_system ? '0 : amp_rise);
	wire [NUM_AXES-1:0] flag_clr  = (state == S_DONE) ? (NUM_AXES'(1) << axis_lat) : '0;

	// read mux
	wire [31:0]         status_w  = {8'h00, err_code, 5'h00, travel_bad, lim_err, zph_err, refuse_flag,
	                                 accept_flag, done_flag, (state != S_IDLE), homing_request_flag};
	logic [31:0]        rd_mux;
	always_comb begin
		case (a_addr)
			ADDR_CTRL:     rd_mux = {18'h0_0000, ctrl};
			ADDR_POST_DOG: rd_mux = post_dog;
			ADDR_SHIFT:    rd_mux = shift_amt;
			ADDR_DWELL:    rd_mux = {16'h0000, dwell_ms};
			ADDR_TORQUE:   rd_mux = {16'h0000, torque_reg};
			ADDR_STATUS:   rd_mux = status_w;
			ADDR_TRAVEL:   rd_mux = travel_mon;
			default:       rd_mux = 32'h0000_0000;
		endcase
	end

	// ahb slave: zero wait states, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_wr    <= 1'b0;
			dph_addr  <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			dph_wr    <= addr_ph && hwrite;
			dph_addr  <= a_addr;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (addr_ph && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// parameter registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl       <= CTRL_RESET;
			post_dog   <= 32'h0000_0000;
			shift_amt  <= 32'h0000_0000;
			dwell_ms   <= DWELL_RESET;
			torque_reg <= TORQUE_RESET;
		end else if (dph_wr) begin
			case (dph_addr)
				ADDR_CTRL:     ctrl       <= hwdata[CTRL_W-1:0];
				ADDR_POST_DOG: post_dog   <= hwdata;
				ADDR_SHIFT:    shift_amt  <= hwdata;
				ADDR_DWELL:    dwell_ms   <= hwdata[15:0];
				ADDR_TORQUE:   torque_reg <= hwdata[15:0];
				default:       ;
			endcase
		end
	end

	// request flags and program start answer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			homing_request_flag <= FLAGS_RESET;
			prog_go             <= 1'b0;
			prog_err            <= 1'b0;
			accept_flag         <= 1'b0;
			refuse_flag         <= 1'b0;
			err_code            <= 8'h00;
		end else begin
			homing_request_flag <= (homing_request_flag & ~flag_clr) | flag_set;
			prog_go             <= wr_prog && !refuse;
			prog_err            <= wr_prog && refuse;
			if (wr_prog) begin
				accept_flag <= !refuse;
				refuse_flag <= refuse;
				err_code    <= refuse ? ERR_NOT_HOMED : 8'h00;
			end
		end
	end

	// sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: begin
				if (start_req && ref_ok) begin
					if ((hwdata[13:10] == M_DSET1) || (hwdata[13:10] == M_DSET2)) begin
						next_state = S_DONE;
					end else if (is_stopper(hwdata[13:10])) begin
						next_state = S_PRESS;
					end else if (hwdata[13:10] == M_DRIVER) begin
						next_state = S_SEEK;
					end else begin
						next_state = S_FAST;
					end
				end
			end
			S_FAST: begin
				if (pins[PIN_DOG]) begin
					next_state = is_count(meth_lat) ? S_COUNT : S_SEEK;
				end else if (lim_hit) begin
					next_state = (ctrl.retry_en && retry_ok(meth_lat)) ? S_DWELL : S_IDLE;
				end
			end
			S_DWELL:   next_state = (cnt >= {16'h0000, dwell_ms}) ? S_FAST : S_DWELL;
			S_COUNT:   next_state = (cnt >= post_lat) ? S_SEEK : S_COUNT;
			S_SEEK: begin
				if (zero_rise) begin
					next_state = do_shift ? S_SHIFT : S_DONE;
				end
			end
			S_SHIFT:   next_state = (cnt >= sh_mag) ? S_DONE : S_SHIFT;
			S_PRESS:   next_state = pins[PIN_LIM] ? S_DONE : S_PRESS;
			S_DONE:    next_state = S_IDLE;
			default:   next_state = S_IDLE;
		endcase
	end

	// sequencer state, counters and latched parameters
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state    <= S_IDLE;
			meth_lat <= M_DOG1;
			axis_lat <= 2'h0;
			post_lat <= 32'h0000_0000;
			sh_lat   <= 32'h0000_0000;
			dir_q    <= 1'b0;
			cnt      <= 32'h0000_0000;
			ms_cnt   <= 32'h0000_0000;
			step_q   <= 1'b0;
			zero_q   <= 1'b0;
			amp_q    <= '0;
			lim_hold <= 1'b0;
		end else begin
			state  <= next_state;
			step_q <= pins[PIN_STEP];
			zero_q <= pins[PIN_ZERO];
			amp_q  <= pins[PIN_AMP +: NUM_AXES];
			lim_hold <= (state == S_FAST && next_state == S_DWELL) || (lim_hold && pins[PIN_LIM]);
			ms_cnt <= (state == S_DWELL && !ms_tick) ? ms_cnt + 32'h0000_0001 : 32'h0000_0000;
			if (state != next_state) begin
				cnt <= 32'h0000_0000;
			end else if ((step_rise && (state == S_COUNT || state == S_SHIFT)) || ms_tick) begin
				cnt <= cnt + 32'h0000_0001;
			end
			if (state == S_IDLE && start_req) begin
				meth_lat <= hwdata[13:10];
				axis_lat <= hwdata[1:0];
				dir_q    <= hwdata[2];
				post_lat <= post_dog;
				sh_lat   <= shift_amt;
			end else if (state == S_FAST && next_state == S_DWELL) begin
				dir_q <= !dir_q;
			end else if (next_state == S_SHIFT && state != S_SHIFT) begin
				dir_q <= !sh_lat[31];
			end
		end
	end

	// outcome flags and monitor; a new start clears done and limit error, the travel monitor and its bad flag keep their values
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_flag  <= 1'b0;
			zph_err    <= 1'b0;
			lim_err    <= 1'b0;
			travel_bad <= 1'b0;
			travel_mon <= 32'h0000_0000;
		end else if (state == S_IDLE && start_req) begin
			done_flag <= 1'b0;
			zph_err   <= !ref_ok;
			lim_err   <= 1'b0;
		end else if (state == S_DONE) begin
			done_flag <= 1'b1;
			if (is_count(meth_lat)) begin
				travel_mon <= trv_sum[31:0];
				travel_bad <= trv_ovf;
			end
		end else if (state == S_FAST && next_state == S_IDLE) begin
			lim_err <= 1'b1;
		end
	end

	// motion command; creep torque limit only while pressing a stopper
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			motion       <= '0;
			torque_limit <= 16'h0000;
		end else begin
			motion.run           <= (state == S_FAST) || (state == S_COUNT) || (state == S_SEEK) ||
			                        (state == S_SHIFT) || (state == S_PRESS);
			motion.dir           <= dir_q;
			motion.creep         <= (state == S_SEEK) || (state == S_PRESS) ||
			                        ((state == S_SHIFT) && ctrl.shift_creep);
			motion.torque_lim_en <= (state == S_PRESS) && is_stopper(meth_lat);
			torque_limit         <= torque_reg;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_REFUSE_CODE: assert property (wr_prog && refuse |=> prog_err && !prog_go && err_code == 8'h79)
		else $error("refused start did not raise code 121");
	AST_SETTING0_GO: assert property (wr_prog && !ctrl.incomplete_stop |=> prog_go)
		else $error("setting 0 blocked a program start");
	AST_JOG_GO: assert property (wr_prog && hwdata[PROG_JOG] |=> prog_go && !prog_err)
		else $error("jog start was blocked");
	AST_VIRTUAL_GO: assert property (wr_prog && (hwdata[PROG_VIRTUAL] || !ctrl.real_mode) |=> prog_go)
		else $error("virtual or non-real start was blocked");
	AST_HOME_ONLY_GO: assert property (wr_prog && hwdata[PROG_HOME_ONLY] |=> prog_go)
		else $error("homing-only program was blocked");
	AST_TORQUE_STOPPER: assert property (motion.torque_lim_en |-> is_stopper(meth_lat) && $past(state) == S_PRESS)
		else $error("torque limit outside stopper press");
	AST_DWELL_STOP: assert property ((state == S_DWELL)[*2] |-> !motion.run && retry_ok(meth_lat))
		else $error("motion during dwell or retry on wrong method");
	AST_SHIFT_DIR: assert property ((state == S_SHIFT)[*2] |-> motion.dir == !sh_lat[31] && do_shift)
		else $error("shift direction does not follow sign");
	AST_FLAG_CLEAR: assert property (state == S_DONE && !flag_set[axis_lat] |=> !homing_request_flag[axis_lat])
		else $error("request flag not cleared after homing");
	AST_ZPHASE_BLOCK: assert property (state == S_IDLE && start_req && !ref_ok |=> state == S_IDLE && zph_err)
		else $error("homing started without zero pulse pass");
	AST_COUNT_ZERO: assert property (state == S_COUNT && cnt >= post_lat |=> state == S_SEEK ##1 motion.creep)
		else $error("count travel did not hand over to zero search");

endmodule

/* bench/hpi_servo_model.sv */
// servo amplifier and motor model: encoder steps, proximity dog, zero pulse, limits
// assumes the motion bundle is registered on hclk; park puts the carriage back at 0
`timescale 1ns/10ps
module hpi_servo_model (
	// clock and bench control
	input  wire logic                 hclk,
	input  wire logic                 park,
	// motion command in
	input  wire hpi_pkg::hpi_motion_s motion,
	// sensor pins out
	output logic                      dog_in,
	output logic                      zero_pulse_in,
	output logic                      enc_step_in,
	output logic                      limit_in,
	output logic                      ref_passed_in
);
	import hpi_pkg::*;
	logic signed [31:0] pos;
	logic [2:0]         phase;

	// one step per eight cycles so every pin level outlasts the synchroniser
	always_ff @(posedge hclk) begin
		if (park) begin
			pos           <= 32'sh0000_0000;
			phase         <= 3'h0;
			ref_passed_in <= 1'b0;
		end else begin
			phase <= motion.run ? phase + 3'h1 : 3'h0;
			if (motion.run && phase == 3'h3)
				pos <= motion.dir ? pos + 1 : pos - 1;
			if (zero_pulse_in)
				ref_passed_in <= 1'b1;
		end
	end

	// dog lies far past the deceleration distance from homing speed
	assign dog_in        = (pos >= 40) && (pos <= 60);
	assign enc_step_in   = phase[2];
	assign zero_pulse_in = (pos[3:0] == 4'h5);
	// stopper contact only while pressing, travel limits otherwise
	assign limit_in      = motion.torque_lim_en ? (pos >= 30) : ((pos <= -20) || (pos >= 200));
endmodule

/* bench/homing_parameter_interlock_tb_top.sv */
// self-checking bench: ahb-lite register tasks, interlock table, homing runs
// assumes hpi_top with a shortened millisecond and the servo model on its pins
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module homing_parameter_interlock_tb_top;
	import hpi_pkg::*;
	localparam int MSC = 10;
	logic                hclk, hresetn, hsel, hwrite, park, mon_clr;
	logic [31:0]         haddr, hwdata, hrdata, q;
	logic [1:0]          htrans;
	logic [2:0]          hsize;
	logic                hreadyout, hresp, prog_go, prog_err;
	logic                dog_in, zero_pulse_in, enc_step_in, limit_in, ref_passed_in;
	logic [NUM_AXES-1:0] amp, flags;
	hpi_motion_s         motion;
	logic [15:0]         torque_limit;
	logic [19:0]         row;
	logic                run_seen, last_dir, last_creep, tq_seen;
	int                  stop_cnt, stop_max, go_n, err_n, n;
	int                  err_total = 0;
	int                  checks_done = 0;
	localparam logic [19:0] TAB [0:6] = '{20'h2_2001, 20'h2_2011, 20'h2_2041, 20'h2_2021,
		20'h3_2001, 20'h2_0001, 20'h0_2001};

	hpi_top #(.MS_CYCLES(MSC)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dog_in(dog_in),
		.zero_pulse_in(zero_pulse_in), .enc_step_in(enc_step_in), .limit_in(limit_in),
		.ref_passed_in(ref_passed_in), .amp_power_up_in(amp), .motion(motion),
		.torque_limit(torque_limit), .homing_request_flag(flags), .prog_go(prog_go), .prog_err(prog_err));
	hpi_servo_model i_servo (.hclk(hclk), .park(park), .motion(motion), .dog_in(dog_in),
		.zero_pulse_in(zero_pulse_in), .enc_step_in(enc_step_in), .limit_in(limit_in),
		.ref_passed_in(ref_passed_in));

	// clock
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	// one word transfer; address phase held until hready, then data phase
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		haddr  <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'b10;
		hsel   <= 1'b1;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	// start homing and poll status until busy drops; read just after a write already sees new data
	task automatic home(input logic [3:0] m, input logic [9:0] lo);
		// park long enough that the old dog level has left the synchroniser
		park <= 1'b1;
		repeat (6) @(posedge hclk);
		park    <= 1'b0;
		mon_clr <= 1'b1;
		xfer(1'b1, ADDR_CTRL, {15'h0000, 1'b1, 2'b00, m, lo}, q);
		mon_clr <= 1'b0;
		n = 0;
		do begin
			xfer(1'b0, ADDR_STATUS, 32'h0000_0000, q);
			n++;
		end while ((n < 3 || q[ST_BUSY] === 1'b1) && n < 2000);
		if (n >= 2000) err_total++;
	endtask

	task automatic conclude();
		$display("checks_done=%0d err_total=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// motion monitor; stop length counted only away from the dog, where dwell happens
	always @(posedge hclk) begin
		if (prog_go === 1'b1) go_n <= go_n + 1;
		if (prog_err === 1'b1) err_n <= err_n + 1;
		if (mon_clr) begin
			run_seen <= 1'b0;
			tq_seen  <= 1'b0;
			stop_cnt <= 0;
			stop_max <= 0;
		end else if (motion.run === 1'b1) begin
			run_seen   <= 1'b1;
			last_dir   <= motion.dir;
			last_creep <= motion.creep;
			tq_seen    <= tq_seen | motion.torque_lim_en;
			stop_cnt   <= 0;
		end else if (run_seen && !dog_in) begin
			stop_cnt <= stop_cnt + 1;
			if (stop_cnt + 1 > stop_max) stop_max <= stop_cnt + 1;
		end
	end

	// watchdog well beyond the expected run length
	initial begin
		#300000;
		err_total++;
		conclude();
	end

	initial begin
		{hsel, hwrite, htrans, haddr, hwdata, amp, mon_clr, go_n, err_n} = '0;
		hsize   = 3'b010;
		park    = 1'b1;
		hresetn = 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`CHK(flags, 4'hF)
		xfer(1'b0, ADDR_CTRL, 32'h0000_0000, q);
		`CHK(q, 32'h0000_0220)
		xfer(1'b0, 8'h24, 32'h0000_0000, q);
		`CHK(q, 32'h0000_0000)
		`CHK(hresp, 1'b0)
		// interlock table: refused only under setting 1, real mode, plain program, unhomed axis
		for (int i = 0; i < 7; i++) begin
			row = TAB[i];
			xfer(1'b1, ADDR_CTRL, {20'h0_0000, row[19:8]}, q);
			xfer(1'b1, ADDR_PROG, {24'h00_0000, row[7:0]}, q);
			@(posedge hclk);
			xfer(1'b0, ADDR_STATUS, 32'h0000_0000, q);
			`CHK({q[23:16], q[7:6]}, (row[13] && row[17] && row[6:4] == 3'h0) ? 10'h1E6 : 10'h001)
		end
		`CHK(err_n, 2)
		`CHK(go_n, 5)
		xfer(1'b1, ADDR_POST_DOG, 32'h0000_0014, q);
		xfer(1'b1, ADDR_SHIFT, 32'h0000_0005, q);
		xfer(1'b1, ADDR_DWELL, 32'h0000_0002, q);
		xfer(1'b1, ADDR_TORQUE, 32'h0000_01F4, q);
		home(M_COUNT1, 10'h224);
		`CHK({q[ST_ZPH_ERR], flags[0], run_seen}, 3'b110)
		home(M_COUNT1, 10'h264);
		`CHK({q[ST_DONE], q[ST_TRV_BAD], flags[0], last_dir, last_creep, tq_seen}, 6'b100100)
		xfer(1'b0, ADDR_TRAVEL, 32'h0000_0000, q);
		`CHK(q, 32'h0000_0019)
		xfer(1'b1, ADDR_SHIFT, 32'hFFFF_FFFD, q);
		home(M_COUNT2, 10'h275);
		`CHK({q[ST_DONE], flags[1], last_dir, last_creep}, 4'b1001)
		xfer(1'b0, ADDR_TRAVEL, 32'h0000_0000, q);
		`CHK(q, 32'h0000_0011)
		home(M_STOP1, 10'h266);
		`CHK({q[ST_DONE], flags[2], tq_seen}, 3'b101)
		`CHK(torque_limit, 16'h01F4)
		home(M_DOG1, 10'h26B);
		`CHK({q[ST_DONE], q[ST_LIM_ERR], flags[3]}, 3'b100)
		`CHK(stop_max >= 2 * MSC && stop_max <= 2 * MSC + 12, 1'b1)
		home(M_LIMSW, 10'h26B);
		`CHK({q[ST_DONE], q[ST_LIM_ERR]}, 2'b01)
		xfer(1'b1, ADDR_SHIFT, 32'h0000_0005, q);
		home(M_DSET1, 10'h264);
		`CHK({q[ST_DONE], run_seen}, 2'b10)
		// amplifier power-up sets the flag only outside an absolute system
		xfer(1'b1, ADDR_CTRL, 32'h0000_0220, q);
		amp <= 4'h1;
		repeat (8) @(posedge hclk);
		xfer(1'b1, ADDR_CTRL, 32'h0000_02A0, q);
		amp <= 4'h3;
		repeat (8) @(posedge hclk);
		xfer(1'b1, ADDR_FLAG_SET, 32'h0000_0004, q);
		repeat (2) @(posedge hclk);
		`CHK(flags, 4'h5)
		conclude();
	end
endmodule
